// ---- hw/start_decoder_pkg.sv ----
// constants, register map and carrier types of the operation-start decoder
// assumes one 100 MHz system clock and the plain register port of the driver core
package start_decoder_pkg;

   // ==========================================================
   // input vector layout
   localparam int DATA_NO_W = 6;
   localparam int NUM_INPUTS = 8;
   localparam int IDX_START = 6;
   localparam int IDX_SEQ = 7;

   // ==========================================================
   // register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_POLARITY = 8'h04;
   localparam logic [7:0] REG_NET_IN = 8'h08;
   localparam logic [7:0] REG_SEL_STATUS = 8'h0C;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h14;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h18;
   localparam logic [7:0] REG_ALARM_CLEAR = 8'h1C;

   // ==========================================================
   // field positions
   localparam int CTRL_ALARM_EN_BIT = 0;
   localparam int ST_SEL_LSB = 0;
   localparam int ST_LAST_LSB = 8;
   localparam int ST_ORIGIN_BIT = 16;
   localparam int ST_HOME_BIT = 17;
   localparam int ST_ALARM_BIT = 18;
   localparam int IRQ_W = 3;
   localparam int IRQ_LAUNCH = 0;
   localparam int IRQ_SEQ = 1;
   localparam int IRQ_ALARM = 2;

   // ==========================================================
   // values after reset
   localparam logic ALARM_EN_RST = 1'b0;
   localparam logic [7:0] POLARITY_RST = 8'h00;
   localparam logic [7:0] NET_IN_RST = 8'h00;
   localparam logic [5:0] LAST_USED_RST = 6'h3F;
   localparam logic [2:0] IRQ_RST = 3'h0;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic valid;
      logic sequential;
      logic [5:0] data_no;
   } launch_t;

   // wraps from 63 back to 0
   function automatic logic [5:0] next_data_no(input logic [5:0] cur);
      next_data_no = cur + 6'h01;
   endfunction : next_data_no

endpackage : start_decoder_pkg

// ---- hw/input_conditioner.sv ----
// three-stage synchroniser, agreement filter and contact polarity for direct inputs
// assumes raw levels are photocoupler current states from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module input_conditioner #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] current_raw,
   input wire logic [WIDTH-1:0] normally_closed,
   output logic [WIDTH-1:0] asserted
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] stable_q;
   logic [WIDTH-1:0] stable_d;

   // ==========================================================
   // filter: a change counts once stages two and three agree
   always_comb begin
      stable_d = stable_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            stable_d[i] = s2_q[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         stable_q <= '0;
      end else begin
         s1_q <= current_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         stable_q <= stable_d;
      end
   end

   // normally-closed contacts read as on while no current flows
   assign asserted = stable_q ^ normally_closed;

endmodule : input_conditioner
`default_nettype wire

// ---- hw/motion_start_input_decoder.sv ----
// operation-start decoder: select lines, start and sequential start to launch requests
// assumes origin and home status come from position logic on sys_clk; direct pins are async
`timescale 1ns/1ps
`default_nettype none
module motion_start_input_decoder
   import start_decoder_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic data_sel_bit0,
   input wire logic data_sel_bit1,
   input wire logic data_sel_bit2,
   input wire logic data_sel_bit3,
   input wire logic data_sel_bit4,
   input wire logic data_sel_bit5,
   input wire logic start_in,
   input wire logic sequential_start,
   input wire logic origin_set,
   input wire logic motor_at_home,
   input wire start_decoder_pkg::bus_req_t bus_req,
   output logic [31:0] rd_data,
   output start_decoder_pkg::launch_t launch,
   output logic alarm_out,
   output logic home_pos_out,
   output logic irq
);
   import start_decoder_pkg::*;

   // ==========================================================
   // register file state
   logic alarm_en_q;
   logic alarm_en_d;
   logic [7:0] polarity_q;
   logic [7:0] polarity_d;
   logic [7:0] net_in_q;
   logic [7:0] net_in_d;
   logic [IRQ_W-1:0] irq_en_q;
   logic [IRQ_W-1:0] irq_en_d;
   logic irq_clr_wr;
   logic alarm_clr_wr;

   always_comb begin
      alarm_en_d = alarm_en_q;
      polarity_d = polarity_q;
      net_in_d = net_in_q;
      irq_en_d = irq_en_q;
      irq_clr_wr = 1'b0;
      alarm_clr_wr = 1'b0;
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            REG_CTRL: begin
               alarm_en_d = bus_req.wdata[CTRL_ALARM_EN_BIT];
            end
            REG_POLARITY: begin
               polarity_d = bus_req.wdata[7:0];
            end
            REG_NET_IN: begin
               net_in_d = bus_req.wdata[7:0];
            end
            REG_IRQ_ENABLE: begin
               irq_en_d = bus_req.wdata[IRQ_W-1:0];
            end
            REG_IRQ_CLEAR: begin
               irq_clr_wr = 1'b1;
            end
            REG_ALARM_CLEAR: begin
               alarm_clr_wr = bus_req.wdata[0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_en_q <= ALARM_EN_RST;
         polarity_q <= POLARITY_RST;
         net_in_q <= NET_IN_RST;
         irq_en_q <= IRQ_RST;
      end else begin
         alarm_en_q <= alarm_en_d;
         polarity_q <= polarity_d;
         net_in_q <= net_in_d;
         irq_en_q <= irq_en_d;
      end
   end

   // ==========================================================
   // input conditioning: direct contacts or'ed with network bits
   logic [NUM_INPUTS-1:0] direct_lvl;
   logic [NUM_INPUTS-1:0] in_lvl;
   logic [DATA_NO_W-1:0] sel_lvl;
   logic start_lvl;
   logic seq_lvl;

   input_conditioner #(
      .WIDTH(NUM_INPUTS)
   ) u_cond (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .current_raw({sequential_start, start_in, data_sel_bit5, data_sel_bit4,
                    data_sel_bit3, data_sel_bit2, data_sel_bit1, data_sel_bit0}),
      .normally_closed(polarity_q),
      .asserted(direct_lvl)
   );

   // network bits read as on when 1, either source may assert an input
   assign in_lvl = direct_lvl | net_in_q;
   // highest-numbered select line is the most significant bit
   assign sel_lvl = in_lvl[DATA_NO_W-1:0];
   assign start_lvl = in_lvl[IDX_START];
   assign seq_lvl = in_lvl[IDX_SEQ];

   // ==========================================================
   // edge detection and launch
   logic start_prev_q;
   logic seq_prev_q;
   logic start_rise;
   logic seq_rise;
   logic [DATA_NO_W-1:0] last_q;
   logic [DATA_NO_W-1:0] last_d;
   launch_t launch_q;
   launch_t launch_d;

   // a held input launches once; a new launch needs the input to drop first
   assign start_rise = start_lvl & ~start_prev_q;
   assign seq_rise = seq_lvl & ~seq_prev_q;

   always_comb begin
      last_d = last_q;
      launch_d = '0;
      // plain start wins when both rise together; the sequential edge is dropped
      if (start_rise) begin
         launch_d.valid = 1'b1;
         launch_d.sequential = 1'b0;
         launch_d.data_no = sel_lvl;
         last_d = sel_lvl;
      end else if (seq_rise) begin
         launch_d.valid = 1'b1;
         launch_d.sequential = 1'b1;
         launch_d.data_no = next_data_no(last_q);
         last_d = next_data_no(last_q);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_prev_q <= 1'b0;
         seq_prev_q <= 1'b0;
         last_q <= LAST_USED_RST;
         launch_q <= '0;
      end else begin
         start_prev_q <= start_lvl;
         seq_prev_q <= seq_lvl;
         last_q <= last_d;
         launch_q <= launch_d;
      end
   end

   assign launch = launch_q;

   // ==========================================================
   // alarm, home status and interrupts
   logic alarm_q;
   logic alarm_d;
   logic alarm_event;
   logic home_q;
   logic [IRQ_W-1:0] irq_status_q;
   logic [IRQ_W-1:0] irq_status_d;
   logic [IRQ_W-1:0] irq_events;
   logic irq_q;
   logic irq_d;

   assign alarm_event = launch_d.valid & alarm_en_q & ~origin_set;
   assign irq_events = {alarm_event, launch_d.valid & launch_d.sequential,
                        launch_d.valid & ~launch_d.sequential};

   always_comb begin
      alarm_d = alarm_q;
      if (alarm_clr_wr) begin
         alarm_d = 1'b0;
      end
      // a new alarm beats a clear in the same cycle
      if (alarm_event) begin
         alarm_d = 1'b1;
      end
      irq_status_d = irq_status_q;
      if (irq_clr_wr) begin
         irq_status_d = irq_status_q & ~bus_req.wdata[IRQ_W-1:0];
      end
      irq_status_d = irq_status_d | irq_events;
      // use the next enable too, so the level never lags a write to the enable register
      irq_d = |(irq_status_d & irq_en_d);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_q <= 1'b0;
         home_q <= 1'b0;
         irq_status_q <= IRQ_RST;
         irq_q <= 1'b0;
      end else begin
         alarm_q <= alarm_d;
         home_q <= motor_at_home;
         irq_status_q <= irq_status_d;
         irq_q <= irq_d;
      end
   end

   assign alarm_out = alarm_q;
   assign home_pos_out = home_q;
   assign irq = irq_q;

   // ==========================================================
   // read port: data stand one cycle after the strobe, zero otherwise
   logic [31:0] rd_q;
   logic [31:0] rd_d;

   always_comb begin
      rd_d = 32'h0000_0000;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            REG_CTRL: begin
               rd_d[CTRL_ALARM_EN_BIT] = alarm_en_q;
            end
            REG_POLARITY: begin
               rd_d[7:0] = polarity_q;
            end
            REG_NET_IN: begin
               rd_d[7:0] = net_in_q;
            end
            REG_SEL_STATUS: begin
               rd_d[ST_SEL_LSB +: DATA_NO_W] = sel_lvl;
               rd_d[ST_LAST_LSB +: DATA_NO_W] = last_q;
               rd_d[ST_ORIGIN_BIT] = origin_set;
               rd_d[ST_HOME_BIT] = home_q;
               rd_d[ST_ALARM_BIT] = alarm_q;
            end
            REG_IRQ_STATUS: begin
               rd_d[IRQ_W-1:0] = irq_status_q;
            end
            REG_IRQ_ENABLE: begin
               rd_d[IRQ_W-1:0] = irq_en_q;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 32'h0000_0000;
      end else begin
         rd_q <= rd_d;
      end
   end

   assign rd_data = rd_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence start_edge_s;
      start_rise;
   endsequence

   sequence plain_launch_s;
      launch_q.valid && !launch_q.sequential && launch_q.data_no == $past(sel_lvl);
   endsequence

   sequence seq_edge_s;
      seq_rise && !start_rise;
   endsequence

   sequence seq_launch_s;
      launch_q.valid && launch_q.sequential &&
         launch_q.data_no == next_data_no($past(last_q));
   endsequence

   start_launch_a: assert property (start_edge_s |=> plain_launch_s)
      else $error("start edge did not launch the selected number");

   seq_launch_a: assert property (seq_edge_s |=> seq_launch_s)
      else $error("sequential start did not use the following number");

   held_once_a: assert property (start_lvl [*3] |-> !start_rise)
      else $error("held start produced another edge");

   launch_cause_a: assert property (launch_q.valid |->
      $past(start_rise) || $past(seq_rise))
      else $error("launch without an input edge");

   net_polarity_a: assert property (net_in_q[IDX_START] |-> start_lvl)
      else $error("network start bit not read as asserted");

   select_map_a: assert property (sel_lvl == {in_lvl[5], in_lvl[4], in_lvl[3],
      in_lvl[2], in_lvl[1], in_lvl[0]})
      else $error("select number not formed msb first");

   alarm_set_a: assert property ((start_rise || seq_rise) && alarm_en_q && !origin_set
      |=> alarm_out)
      else $error("home-incomplete alarm not raised");

   alarm_cause_a: assert property ($rose(alarm_out) |->
      $past(alarm_en_q) && !$past(origin_set) && launch_q.valid)
      else $error("alarm raised without its cause");

   alarm_hold_a: assert property (alarm_out && !alarm_clr_wr |=> alarm_out)
      else $error("alarm dropped without a clear");

   home_follow_a: assert property ($past(rst_n) |-> home_pos_out == $past(motor_at_home))
      else $error("home status does not follow home position");

   alarm_en_read_a: assert property (bus_req.rd && bus_req.addr == REG_CTRL
      |=> rd_data[CTRL_ALARM_EN_BIT] == $past(alarm_en_q) && rd_data[31:1] == '0)
      else $error("alarm enable read back wrong");

   irq_level_a: assert property (##1 irq == |(irq_status_q & irq_en_q))
      else $error("interrupt level does not match enabled status");

endmodule : motion_start_input_decoder
`default_nettype wire

// ---- verification/host_plc_model.sv ----
// host controller model driving the decoder's direct photocoupler pins
// assumes the bench states the wanted logical levels; model turns them into contact current
`timescale 1ns/1ps
`default_nettype none
module host_plc_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [5:0] want_sel,
   input wire logic want_start,
   input wire logic want_seq,
   input wire logic [7:0] nc_mask,
   output logic [5:0] sel_current,
   output logic start_current,
   output logic seq_current
);
   // ==========================================================
   // start lines lag the select lines so selects settle first
   logic [5:0] start_dly_q;
   logic [5:0] seq_dly_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_dly_q <= '0;
         seq_dly_q <= '0;
      end else begin
         start_dly_q <= {start_dly_q[4:0], want_start};
         seq_dly_q <= {seq_dly_q[4:0], want_seq};
      end
   end
   // ==========================================================
   // normally-closed contacts carry current while not asserted
   assign sel_current = want_sel ^ nc_mask[5:0];
   assign start_current = start_dly_q[5] ^ nc_mask[6];
   assign seq_current = seq_dly_q[5] ^ nc_mask[7];
endmodule : host_plc_model
`default_nettype wire

// ---- verification/motion_start_input_decoder_tb_top.sv ----
// self-checking bench of the operation-start decoder
// assumes host_plc_model drives the direct pins; network bits go through the register port
`timescale 1ns/1ps
`default_nettype none
module motion_start_input_decoder_tb_top;
   import start_decoder_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic origin_set = 1'b0;
   logic motor_at_home = 1'b0;
   bus_req_t bus_req = '0;
   logic [31:0] rd_data;
   launch_t launch;
   logic alarm_out;
   logic home_pos_out;
   logic irq;
   logic [5:0] sel_pins;
   logic start_pin;
   logic seq_pin;
   logic [5:0] host_sel = 6'h00;
   logic host_start = 1'b0;
   logic host_seq = 1'b0;
   logic [7:0] host_nc = 8'h00;
   launch_t seen_q[$];
   int num_errors = 0;
   int checked = 0;
   logic [5:0] last_no = 6'h3F;
   logic [5:0] r;
   logic [7:0] nc_v;

   host_plc_model u_host (.sys_clk(sys_clk), .rst_n(rst_n), .want_sel(host_sel),
      .want_start(host_start), .want_seq(host_seq), .nc_mask(host_nc),
      .sel_current(sel_pins), .start_current(start_pin), .seq_current(seq_pin));

   motion_start_input_decoder u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .data_sel_bit0(sel_pins[0]), .data_sel_bit1(sel_pins[1]), .data_sel_bit2(sel_pins[2]),
      .data_sel_bit3(sel_pins[3]), .data_sel_bit4(sel_pins[4]), .data_sel_bit5(sel_pins[5]),
      .start_in(start_pin), .sequential_start(seq_pin), .origin_set(origin_set),
      .motor_at_home(motor_at_home), .bus_req(bus_req), .rd_data(rd_data), .launch(launch),
      .alarm_out(alarm_out), .home_pos_out(home_pos_out), .irq(irq));

   // ==========================================================
   // clock, launch capture, watchdog
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (launch.valid === 1'b1) seen_q.push_back(launch);
   end
   initial begin
      #300us;
      num_errors++;
      results();
   end

   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      bus_req <= '0;
   endtask : bus_wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge sys_clk);
      bus_req <= '0;
      #1 check(rd_data, e);
   endtask : rd_chk
   // waits a bounded time for the next launch and compares kind and number
   task automatic exp_launch(input logic sq, input logic [5:0] no);
      launch_t l;
      for (int n = 0; n < 24 && seen_q.size() == 0; n++) @(posedge sys_clk);
      l = '0;
      if (seen_q.size() != 0) l = seen_q.pop_front();
      check({24'h0, l.valid, l.sequential, l.data_no}, {24'h0, 1'b1, sq, no});
      last_no = no;
   endtask : exp_launch
   function automatic logic [5:0] after(input logic [5:0] n);
      after = (n == 6'h3F) ? 6'h00 : n + 6'h01;
   endfunction : after
   function automatic logic [31:0] st_exp(input logic al);
      st_exp = {13'h0, al, motor_at_home, origin_set, 2'b00, last_no, 2'b00, 6'h00};
   endfunction : st_exp
   task automatic net_start(input logic [5:0] s);
      bus_wr(REG_NET_IN, {24'h0, 2'b01, s});
      bus_wr(REG_NET_IN, 32'h0);
      exp_launch(1'b0, s);
   endtask : net_start
   task automatic net_seq();
      logic [5:0] e;
      e = after(last_no);
      bus_wr(REG_NET_IN, 32'h80);
      bus_wr(REG_NET_IN, 32'h0);
      exp_launch(1'b1, e);
   endtask : net_seq

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'hA12F));
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd_chk(REG_CTRL, 32'h0);
      rd_chk(REG_SEL_STATUS, st_exp(1'b0));
      rd_chk(8'h20, 32'h0);
      rd_chk(REG_IRQ_CLEAR, 32'h0);
      net_seq();
      net_start(6'h3F);
      net_seq();
      net_seq();
      for (int i = 0; i < 8; i++) begin
         r = 6'($urandom);
         net_start(r);
         if (i[0]) net_seq();
      end
      // a held start gives a single launch
      bus_wr(REG_NET_IN, 32'h45);
      repeat (12) @(posedge sys_clk);
      check(32'(seen_q.size()), 32'h1);
      exp_launch(1'b0, 6'h05);
      bus_wr(REG_NET_IN, 32'h0);
      rd_chk(REG_SEL_STATUS, st_exp(1'b0));
      // alarm: enabled without origin, then with origin, then disabled
      bus_wr(REG_CTRL, 32'h1);
      rd_chk(REG_CTRL, 32'h1);
      net_start(6'h2A);
      check({31'h0, alarm_out}, 32'h1);
      rd_chk(REG_SEL_STATUS, st_exp(1'b1));
      rd_chk(REG_IRQ_STATUS, 32'h7);
      bus_wr(REG_ALARM_CLEAR, 32'h1);
      #1 check({31'h0, alarm_out}, 32'h0);
      origin_set <= 1'b1;
      net_seq();
      check({31'h0, alarm_out}, 32'h0);
      origin_set <= 1'b0;
      bus_wr(REG_CTRL, 32'h0);
      net_seq();
      check({31'h0, alarm_out}, 32'h0);
      // interrupt: masked sequential, enabled plain, then cleared
      bus_wr(REG_IRQ_CLEAR, 32'h7);
      bus_wr(REG_IRQ_ENABLE, 32'h1);
      rd_chk(REG_IRQ_ENABLE, 32'h1);
      net_seq();
      rd_chk(REG_IRQ_STATUS, 32'h2);
      check({31'h0, irq}, 32'h0);
      net_start(6'h11);
      repeat (2) @(posedge sys_clk);
      #1 check({31'h0, irq}, 32'h1);
      bus_wr(REG_IRQ_CLEAR, 32'h3);
      repeat (2) @(posedge sys_clk);
      #1 check({31'h0, irq}, 32'h0);
      rd_chk(REG_IRQ_STATUS, 32'h0);
      // home status follows the motor
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         motor_at_home <= i[0];
         repeat (2) @(posedge sys_clk);
         #1 check({31'h0, home_pos_out}, {31'h0, i[0]});
      end
      // direct pins with random contact polarity
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         nc_v = 8'($urandom);
         host_nc <= nc_v;
         bus_wr(REG_POLARITY, {24'h0, nc_v});
         rd_chk(REG_POLARITY, {24'h0, nc_v});
         r = 6'($urandom);
         host_sel <= r;
         repeat (14) @(posedge sys_clk);
         seen_q.delete();
         host_start <= 1'b1;
         exp_launch(1'b0, r);
         host_start <= 1'b0;
         repeat (14) @(posedge sys_clk);
         host_seq <= 1'b1;
         exp_launch(1'b1, after(r));
         host_seq <= 1'b0;
         repeat (14) @(posedge sys_clk);
      end
      // reset in mid-run: settings, alarm and sequence number return to reset values
      bus_wr(REG_CTRL, 32'h1);
      net_start(6'h3F);
      check({31'h0, alarm_out}, 32'h1);
      @(posedge sys_clk);
      host_nc <= 8'h00;
      host_sel <= 6'h00;
      motor_at_home <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      seen_q.delete();
      last_no = 6'h3F;
      check({31'h0, alarm_out}, 32'h0);
      rd_chk(REG_CTRL, 32'h0);
      rd_chk(REG_IRQ_STATUS, 32'h0);
      rd_chk(REG_SEL_STATUS, st_exp(1'b0));
      net_seq();
      check({31'h0, alarm_out}, 32'h0);
      results();
   end
endmodule : motion_start_input_decoder_tb_top
`default_nettype wire
